// File: dv/mcp_clk_src_model.sv
// External clock pin and internal oscillator seen by the block
`timescale 1ns/1ps
`default_nettype none
module mcp_clk_src_model (
  // Control from the bench
  input wire logic ext_run_i,
  // Clock sources
  output logic ext_clk_pin_o,
  output logic int_osc_o
);
  // Pin held grounded while unused, so the detector sees no stray edges
  initial begin
    ext_clk_pin_o = 1'b0;
    #7;
    forever begin
      #200;
      ext_clk_pin_o = ext_run_i ? ~ext_clk_pin_o : 1'b0;
    end
  end
  // Free running oscillator near 32.7 kHz
  initial begin
    int_osc_o = 1'b0;
    forever #15259 int_osc_o = ~int_osc_o;
  end
endmodule : mcp_clk_src_model
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the miscellaneous control register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mcp_pkg::*;
  logic clk_i, rst_i, xfer_start_i, byte_wr_i, byte_rd_i, ext_run, rd_seen;
  logic ext_pin, int_osc, tick, flag, ps, pwm;
  logic [7:0] start_addr_i, byte_wdata_i, adc, rdata, var_d, d;
  logic [1:0] cp;
  logic [7:0] exp_q[$];
  int failures, compares, seed, c;

  mcp_clk_src_model mcp_clk_src_model_inst (.ext_run_i(ext_run),
    .ext_clk_pin_o(ext_pin), .int_osc_o(int_osc));
  mcp_misc_control mcp_misc_control_inst (.clk_i(clk_i), .rst_i(rst_i),
    .xfer_start_i(xfer_start_i), .start_addr_i(start_addr_i),
    .byte_wr_i(byte_wr_i), .byte_wdata_i(byte_wdata_i),
    .byte_rd_i(byte_rd_i), .byte_rdata_o(rdata), .ext_clk_pin_i(ext_pin),
    .int_osc_i(int_osc), .led_test_adc_i(adc), .engine_tick_o(tick),
    .external_clock_in_use_flag_o(flag), .var_d_o(var_d),
    .charge_pump_mode_o(cp), .power_save_enable_o(ps),
    .pwm_power_save_enable_o(pwm));

  // 20 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // One byte access; a read leaves its expected value in the queue
  task automatic op(input logic st, input logic [7:0] a, input logic wr,
                    input logic [7:0] wd, input logic rd,
                    input logic [7:0] e);
    @(posedge clk_i);
    xfer_start_i <= st;
    start_addr_i <= a;
    byte_wr_i <= wr;
    byte_wdata_i <= wd;
    byte_rd_i <= rd;
    if (rd) exp_q.push_back(e);
    @(posedge clk_i);
    xfer_start_i <= 1'b0;
    byte_wr_i <= 1'b0;
    byte_rd_i <= 1'b0;
  endtask : op

  task automatic count_ticks(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (tick === 1'b1) cnt++;
    end
  endtask : count_ticks

  // Read data lands one cycle after the read edge; oldest note first
  always @(posedge clk_i) begin
    if (rd_seen) begin
      check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~rdata);
    end
    rd_seen <= byte_rd_i;
  end

  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  initial begin
    // Read watcher alone drives rd_seen
    {xfer_start_i, byte_wr_i, byte_rd_i} = 3'h0;
    {start_addr_i, byte_wdata_i, adc} = 24'h000000;
    seed = 72;
    ext_run = 1'b0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 check({4'h0, cp, ps, pwm}, 8'h00);
    check(var_d, 8'h00);
    op(1'b1, MISC_CONTROL_ADDR, 1'b0, 8'h00, 1'b1,
       MISC_CONTROL_RESET);
    // Every pump mode, bits 5 and 1:0 random, both variable D sources
    for (int m = 0; m < 4; m++) begin
      d = 8'($random(seed));
      d[7] = m[0];
      d[6] = 1'b1;
      d[4:3] = m[1:0];
      // Host asks for PWM power save only with pump off or in bypass
      d[2] = ~m[1];
      @(posedge clk_i);
      adc <= 8'($random(seed));
      op(1'b1, MISC_CONTROL_ADDR, 1'b1, d, 1'b0, 8'h00);
      op(1'b1, VAR_D_REG_ADDR, 1'b1, ~d, 1'b0, 8'h00);
      repeat (3) @(posedge clk_i);
      #1 check({6'h00, cp}, {6'h00, d[4:3]});
      check({7'h00, ps}, {7'h00, d[5]});
      check({7'h00, pwm}, {7'h00, d[2] & ~d[4]});
      check(var_d, d[7] ? adc : ~d);
      op(1'b1, MISC_CONTROL_ADDR, 1'b0, 8'h00, 1'b1, d);
    end
    // Address held when increment is off, advancing when on
    op(1'b1, MISC_CONTROL_ADDR, 1'b1, 8'h01, 1'b0, 8'h00);
    op(1'b1, MISC_CONTROL_ADDR, 1'b1, 8'h09, 1'b0, 8'h00);
    op(1'b0, 8'h00, 1'b1, 8'h11, 1'b0, 8'h00);
    op(1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 8'h11);
    op(1'b1, MISC_CONTROL_ADDR, 1'b1, 8'h40, 1'b0, 8'h00);
    op(1'b1, 8'h04, 1'b1, 8'hFF, 1'b0, 8'h00);
    op(1'b0, 8'h00, 1'b1, 8'h43, 1'b0, 8'h00);
    op(1'b1, MISC_CONTROL_ADDR, 1'b0, 8'h00, 1'b1, 8'h43);
    op(1'b1, 8'h04, 1'b0, 8'h00, 1'b1, UNMAPPED_READ);
    // Each clock selection with the external pin running
    ext_run <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      op(1'b1, MISC_CONTROL_ADDR, 1'b1, {6'h10, s[1:0]}, 1'b0, 8'h00);
      count_ticks(1000, c);
      check(8'(s[0] ? c < 4 : c > 100), 8'h01);
      check({7'h00, flag}, 8'(s == 2));
      op(1'b1, STATUS_ADDR, 1'b1, 8'hFF, 1'b1, 8'(s == 2));
    end
    // Automatic selection falls back once the pin goes quiet
    op(1'b1, MISC_CONTROL_ADDR, 1'b1, 8'h42, 1'b0, 8'h00);
    ext_run <= 1'b0;
    count_ticks(2200, c);
    check(8'(c < 8), 8'h01);
    check({7'h00, flag}, 8'h00);
    op(1'b1, STATUS_ADDR, 1'b0, 8'h00, 1'b1, 8'h00);
    count_ticks(700, c);
    check(8'(c > 0), 8'h01);
    repeat (3) @(posedge clk_i);
    complete_run();
  end
endmodule : tb
`default_nettype wire

// File: src/mcp_clock_detect.sv
// Pin synchroniser, rising edge finder and activity detector
`timescale 1ns/1ps
`default_nettype none
module mcp_clock_detect
  import mcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous clock input
  input wire logic pin_i,
  // Detector results
  output logic rise_o,
  output logic active_o
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise_reg;
  logic active_reg;
  logic [DET_CNT_W-1:0] cnt_reg;
  logic rise_next;

  // Edge taken from the second stage only
  assign rise_next = sync2_reg & ~prev_reg;

  // Two-stage synchroniser and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      rise_reg <= rise_next;
    end
  end

  // Each rising edge restarts the window; no upper frequency bound is applied
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= DET_CNT_ZERO;
      active_reg <= 1'b0;
    end else if (rise_next) begin
      cnt_reg <= DET_TIMEOUT_CNT;
      active_reg <= 1'b1;
    end else if (cnt_reg != DET_CNT_ZERO) begin
      cnt_reg <= cnt_reg - 12'h001;
    end else begin
      active_reg <= 1'b0;
    end
  end

  assign rise_o = rise_reg;
  assign active_o = active_reg;
endmodule : mcp_clock_detect
`default_nettype wire

// File: src/mcp_misc_control.sv
// Miscellaneous clock and power control register block
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Engine ticks come from the internal oscillator or the clock input pin.
// - Tick rate follows the external clock; detector sets no upper limit.
// - Status flag shows external clock use while detect enable bit is high.
// - Bit 7 picks variable D: register 0x3C or LED test converter value.
// - Bit 6, reset 1, lets the byte address advance within one transfer.
// - Bit 5, reset 0, enables automatic power save.
// - Bits 4:3 set charge pump off, bypass, 1.5x or automatic gain.
// - Bit 2 enables PWM power save; only valid with pump off or bypass.
// - Bits 1:0 pick forced external, forced internal, automatic or internal.
module mcp_misc_control
  import mcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial bus byte port
  input wire logic xfer_start_i,
  input wire logic [7:0] start_addr_i,
  input wire logic byte_wr_i,
  input wire logic [7:0] byte_wdata_i,
  input wire logic byte_rd_i,
  output logic [7:0] byte_rdata_o,
  // Clock sources
  input wire logic ext_clk_pin_i,
  input wire logic int_osc_i,
  // LED test converter result, same clock
  input wire logic [7:0] led_test_adc_i,
  // Controls to the rest of the device
  output logic engine_tick_o,
  output logic external_clock_in_use_flag_o,
  output logic [7:0] var_d_o,
  output logic [1:0] charge_pump_mode_o,
  output logic power_save_enable_o,
  output logic pwm_power_save_enable_o
);
  logic [7:0] misc_control_reg;
  logic [7:0] var_d_src_reg;
  logic [7:0] addr_reg;
  logic [7:0] rdata_reg;
  logic tick_reg;
  logic ext_used_reg;
  logic flag_reg;
  logic [7:0] var_d_reg;
  logic [1:0] charge_pump_mode_reg;
  logic ps_reg;
  logic pwm_ps_reg;
  logic ext_rise;
  logic ext_active;
  logic int_rise;

  wire [7:0] cur_addr;
  wire byte_access;
  wire [7:0] addr_next;
  wire wr_misc;
  wire wr_var_d;
  wire [1:0] clk_sel;
  wire [1:0] charge_pump_mode_f;
  wire ext_used_next;
  wire flag_next;
  wire [7:0] status_word;
  wire [7:0] rdata_next;
  wire [7:0] var_d_next;
  wire pwm_ps_next;

  // External pin and internal oscillator both cross into clk_i here
  mcp_clock_detect u_ext_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_clk_pin_i),
    .rise_o(ext_rise),
    .active_o(ext_active)
  );

  mcp_clock_detect u_int_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(int_osc_i),
    .rise_o(int_rise),
    .active_o()
  );

  // Address of the byte being accessed and where the pointer goes next
  assign cur_addr = xfer_start_i ? start_addr_i : addr_reg;
  assign byte_access = byte_wr_i | byte_rd_i;
  assign addr_next = (byte_access && misc_control_reg[AUTO_INCR_BIT])
                     ? cur_addr + 8'h01 : cur_addr;
  assign wr_misc = byte_wr_i && (cur_addr == MISC_CONTROL_ADDR);
  assign wr_var_d = byte_wr_i && (cur_addr == VAR_D_REG_ADDR);

  // Field decode
  assign clk_sel = misc_control_reg[CLK_SEL_HI:CLK_SEL_LO];
  assign charge_pump_mode_f = misc_control_reg[CHARGE_PUMP_MODE_HI:CHARGE_PUMP_MODE_LO];

  // Clock choice; codes 01 and 11 both run internal
  assign ext_used_next = (clk_sel == CLK_SEL_FORCE_EXT) ||
    ((clk_sel == CLK_SEL_AUTO) && ext_active);
  // Flag only reported while detection is enabled
  assign flag_next = misc_control_reg[CLOCK_DETECT_ENABLE_BIT] &
                     ext_used_next;
  assign status_word = {7'h00, flag_reg} << STATUS_EXT_CLK_BIT;

  // Read mux; unmapped addresses read as zero
  assign rdata_next = (cur_addr == MISC_CONTROL_ADDR) ? misc_control_reg :
                      (cur_addr == STATUS_ADDR) ? status_word :
                      (cur_addr == VAR_D_REG_ADDR) ? var_d_src_reg :
                      UNMAPPED_READ;

  assign var_d_next = misc_control_reg[VAR_D_SEL_BIT] ? led_test_adc_i
                      : var_d_src_reg;
  // Hardware also blocks PWM power save with the pump in 1.5x or auto
  assign pwm_ps_next = misc_control_reg[PWM_PS_BIT] &&
                       ((charge_pump_mode_f == CHARGE_PUMP_MODE_OFF) ||
                        (charge_pump_mode_f == CHARGE_PUMP_MODE_BYPASS));

  // Register storage and byte pointer; status is read only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      misc_control_reg <= MISC_CONTROL_RESET;
      var_d_src_reg <= VAR_D_REG_RESET;
      addr_reg <= 8'h00;
      rdata_reg <= UNMAPPED_READ;
    end else begin
      if (wr_misc) begin
        misc_control_reg <= byte_wdata_i;
      end
      if (wr_var_d) begin
        var_d_src_reg <= byte_wdata_i;
      end
      if (xfer_start_i || byte_access) begin
        addr_reg <= addr_next;
      end
      if (byte_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Engine tick follows the selected clock edge for edge, up to half the clk_i rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_reg <= 1'b0;
      ext_used_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      tick_reg <= ext_used_next ? ext_rise : int_rise;
      ext_used_reg <= ext_used_next;
      flag_reg <= flag_next;
    end
  end

  // Registered control outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      var_d_reg <= VAR_D_REG_RESET;
      charge_pump_mode_reg <= CHARGE_PUMP_MODE_OFF;
      ps_reg <= 1'b0;
      pwm_ps_reg <= 1'b0;
    end else begin
      var_d_reg <= var_d_next;
      charge_pump_mode_reg <= charge_pump_mode_f;
      ps_reg <= misc_control_reg[POWER_SAVE_BIT];
      pwm_ps_reg <= pwm_ps_next;
    end
  end

  assign byte_rdata_o = rdata_reg;
  assign engine_tick_o = tick_reg;
  assign external_clock_in_use_flag_o = flag_reg;
  assign var_d_o = var_d_reg;
  assign charge_pump_mode_o = charge_pump_mode_reg;
  assign power_save_enable_o = ps_reg;
  assign pwm_power_save_enable_o = pwm_ps_reg;

  // Checks on the register block and clock selection
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_misc_reset_value: assert property (
    $fell(rst_i) |-> misc_control_reg == MISC_CONTROL_RESET)
    else $error("misc control reset value wrong");
  a_incr_enabled: assert property (
    (byte_access && !xfer_start_i && misc_control_reg[AUTO_INCR_BIT])
    |=> addr_reg == $past(addr_reg) + 8'h01)
    else $error("address did not advance");
  a_incr_disabled: assert property (
    (byte_access && !xfer_start_i && !misc_control_reg[AUTO_INCR_BIT])
    |=> $stable(addr_reg))
    else $error("address advanced while disabled");
  a_flag_gated: assert property (
    !misc_control_reg[CLOCK_DETECT_ENABLE_BIT] |=> !flag_reg)
    else $error("flag set with detection disabled");
  a_forced_ext: assert property (
    (clk_sel == CLK_SEL_FORCE_EXT) ##1 (clk_sel == CLK_SEL_FORCE_EXT)
    |-> ext_used_reg && !flag_reg)
    else $error("forced external not honoured");
  // Tick must follow the oscillator edge seen one cycle earlier
  a_internal_sel: assert property (
    clk_sel[0] |=> !ext_used_reg && (tick_reg == $past(int_rise)))
    else $error("internal selection not honoured");
  a_auto_select: assert property (
    (clk_sel == CLK_SEL_AUTO) |=> flag_reg == $past(ext_active))
    else $error("automatic choice mismatch");
  a_var_d_source: assert property (
    1'b1 |=> var_d_o == ($past(misc_control_reg[VAR_D_SEL_BIT])
    ? $past(led_test_adc_i) : $past(var_d_src_reg)))
    else $error("variable D source wrong");
  a_charge_pump_mode_out: assert property (
    wr_misc |=> ##1 charge_pump_mode_o == $past(byte_wdata_i[4:3], 2))
    else $error("charge pump mode not applied");
  a_power_save: assert property (
    1'b1 |=> power_save_enable_o == $past(misc_control_reg[POWER_SAVE_BIT]))
    else $error("power save enable mismatch");
  a_pwm_ps_gate: assert property (
    pwm_power_save_enable_o |-> $past(charge_pump_mode_f) <= CHARGE_PUMP_MODE_BYPASS)
    else $error("PWM power save with high gain pump");

  c_ext_ticks: cover property (ext_used_reg && tick_reg);
  c_auto_fallback: cover property (
    (clk_sel == CLK_SEL_AUTO) && $fell(ext_used_reg));
  // Control byte then variable D source, one idle cycle apart
  c_burst_write: cover property (wr_misc ##2 wr_var_d);
  c_status_read: cover property (
    byte_rd_i && (cur_addr == STATUS_ADDR) && flag_reg);
endmodule : mcp_misc_control
`default_nettype wire

// File: src/mcp_pkg.sv
// Constants for the miscellaneous clock and power control block
package mcp_pkg;
  // Register addresses on the serial control bus
  localparam logic [7:0] MISC_CONTROL_ADDR = 8'h05;
  localparam logic [7:0] STATUS_ADDR = 8'h3A;
  localparam logic [7:0] VAR_D_REG_ADDR = 8'h3C;
  // Reset values
  localparam logic [7:0] MISC_CONTROL_RESET = 8'h40;
  localparam logic [7:0] VAR_D_REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Field positions in misc_control
  localparam int VAR_D_SEL_BIT = 7;
  localparam int AUTO_INCR_BIT = 6;
  localparam int POWER_SAVE_BIT = 5;
  localparam int CHARGE_PUMP_MODE_HI = 4;
  localparam int CHARGE_PUMP_MODE_LO = 3;
  localparam int PWM_PS_BIT = 2;
  localparam int CLOCK_DETECT_ENABLE_BIT = 1;
  localparam int CLK_SEL_HI = 1;
  localparam int CLK_SEL_LO = 0;
  // Position of the external-clock-used flag in the status register
  localparam int STATUS_EXT_CLK_BIT = 0;
  // Clock selection codes
  localparam logic [1:0] CLK_SEL_FORCE_EXT = 2'h0;
  localparam logic [1:0] CLK_SEL_FORCE_INT = 2'h1;
  localparam logic [1:0] CLK_SEL_AUTO = 2'h2;
  localparam logic [1:0] CLK_SEL_INT = 2'h3;
  // Charge pump mode codes
  localparam logic [1:0] CHARGE_PUMP_MODE_OFF = 2'h0;
  localparam logic [1:0] CHARGE_PUMP_MODE_BYPASS = 2'h1;
  localparam logic [1:0] CHARGE_PUMP_MODE_GAIN_1P5 = 2'h2;
  localparam logic [1:0] CHARGE_PUMP_MODE_AUTO = 2'h3;
  // Timing: system clock and activity timeout of the clock detector
  localparam int CLK_PERIOD_NS = 50;
  localparam int DET_TIMEOUT_NS = 100000;
  localparam int DET_TIMEOUT_CYCLES =
    (DET_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DET_CNT_W = 12;
  localparam logic [DET_CNT_W-1:0] DET_TIMEOUT_CNT =
    DET_CNT_W'(DET_TIMEOUT_CYCLES);
  localparam logic [DET_CNT_W-1:0] DET_CNT_ZERO = 12'h000;
endpackage : mcp_pkg
